// ### design/asq_seq_ctrl.v
// Operation
// - After every increment_rate_field+1 finished conversions the DMA address steps and the interrupt event fires.
// - The auto-sample time holds for auto_sample_time_field conversion-clock periods, zero meaning none.
// - One conversion-clock period lasts conversion_clock_select+1 instruction cycles, codes from 64 up being reserved.
// - Each analog input owns a DMA area of 2 to the power buffer_size_per_input words, 1 to 128.
// - Bits 15 to 3 of the buffer-size register read zero and ignore writes.
`timescale 1ns/100ps
`include "asq_consts.vh"

module asq_seq_ctrl #(
	parameter AW = 11
) (
	// Clock and reset
	input  wire          sys_clk,
	input  wire          sys_rst,
	// AXI4-Lite write address
	input  wire [4:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output wire          s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output wire          s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	// AXI4-Lite read address
	input  wire [4:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output wire          s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	// Conversion sequencing
	input  wire          trigger,
	output reg           sampling,
	output reg           converting,
	output reg           conv_done,
	// DMA side
	output reg  [AW-1:0] dma_addr,
	output reg           dma_step,
	input  wire [4:0]    input_index,
	// Channel 1-3 input routing, slot A then slot B
	output reg  [14:0]   pos_sel_a,
	output reg  [14:0]   pos_sel_b,
	output reg  [14:0]   neg_sel_a,
	output reg  [14:0]   neg_sel_b,
	output reg  [2:0]    neg_ref_a,
	output reg  [2:0]    neg_ref_b,
	// Interrupt
	output wire          irq
);
	localparam ST_IDLE   = 3'b001;
	localparam ST_SAMPLE = 3'b010;
	localparam ST_CONV   = 3'b100;

	reg [15:0] con2_reg;
	reg [15:0] timing_reg;
	reg [15:0] bufsize_reg;
	reg [15:0] chsel_reg;
	reg        twelve_bit_mode_reg;
	reg        auto_run_reg;
	reg [1:0]  irq_status_reg;
	reg [1:0]  irq_mask_reg;
	reg [2:0]  state_reg;
	reg [4:0]  tad_cnt_reg;
	reg [3:0]  rate_cnt_reg;
	reg [AW-1:0] ptr_reg;
	reg        aw_done_reg;
	reg        w_done_reg;
	reg [4:0]  aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;

	wire [3:0] increment_rate_field   = con2_reg[`ASQ_RATE_LSB +: 4];
	wire [4:0] auto_sample_time_field = timing_reg[`ASQ_AUTO_SAMPLE_TIME_FIELD_LSB +: 5];
	wire [7:0] conversion_clock_select = timing_reg[`ASQ_CLKSEL_LSB +: 8];
	wire [2:0] buffer_size_per_input  = bufsize_reg[`ASQ_BUFLEN_LSB +: 3];
	wire       positive_select_slot_a = chsel_reg[`ASQ_POSA_BIT];
	wire       positive_select_slot_b = chsel_reg[`ASQ_POSB_BIT];
	wire [1:0] negative_select_slot_a = chsel_reg[`ASQ_NEGA_LSB +: 2];
	wire [1:0] negative_select_slot_b = chsel_reg[`ASQ_NEGB_LSB +: 2];

	// Reserved clock codes are clamped so the divider never runs slower than 64
	wire [7:0] clk_sel_eff = (conversion_clock_select > `ASQ_CLKSEL_MAX) ?
		`ASQ_CLKSEL_MAX : conversion_clock_select;
	wire       tad_tick;

	asq_clk_div #(
		.W (8)
	) u_div (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.sel     (clk_sel_eff),
		.run     (state_reg != ST_IDLE),
		.tick    (tad_tick)
	);

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  st;
		input [15:0] wmask;
		reg   [15:0] t;
		begin
			t = old;
			if (st[0])
				t[7:0] = wd[7:0];
			if (st[1])
				t[15:8] = wd[15:8];
			merge16 = t & wmask;
		end
	endfunction

	// Three five-bit input numbers packed for channels 1,2,3
	function [14:0] trio;
		input [4:0] base;
		begin
			trio = {base + 5'd2, base + 5'd1, base};
		end
	endfunction

	// AXI write path: address and data taken in either order
	assign s_axi_awready = !aw_done_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_done_reg && !s_axi_bvalid;
	wire   wr_fire = aw_done_reg && w_done_reg;
	wire   wr_known = (aw_addr_reg == `ASQ_ADDR_CON2) || (aw_addr_reg == `ASQ_ADDR_TIMING) ||
		(aw_addr_reg == `ASQ_ADDR_BUFSIZE) || (aw_addr_reg == `ASQ_ADDR_CHSEL) ||
		(aw_addr_reg == `ASQ_ADDR_MODE) || (aw_addr_reg == `ASQ_ADDR_IRQ_STATUS) ||
		(aw_addr_reg == `ASQ_ADDR_IRQ_MASK);

	assign s_axi_arready = !s_axi_rvalid;
	wire   rd_fire = s_axi_arvalid && s_axi_arready;

	// Sequencer events
	wire conv_end  = (state_reg == ST_CONV) && tad_tick && (tad_cnt_reg == `ASQ_CONV_TAD - 1);
	wire step_now  = conv_end && (rate_cnt_reg == increment_rate_field);
	wire rd_status = rd_fire && (s_axi_araddr == `ASQ_ADDR_IRQ_STATUS);

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_done_reg <= 1'b0;
			w_done_reg  <= 1'b0;
			aw_addr_reg <= 5'h00;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ASQ_RESP_OKAY;
			con2_reg    <= `ASQ_CON2_RST;
			timing_reg  <= `ASQ_TIMING_RST;
			bufsize_reg <= `ASQ_BUFSIZE_RST;
			chsel_reg   <= `ASQ_CHSEL_RST;
			twelve_bit_mode_reg <= 1'b0;
			auto_run_reg <= 1'b0;
			irq_mask_reg <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_done_reg  <= 1'b0;
				w_done_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
				case (aw_addr_reg)
				`ASQ_ADDR_CON2:
					con2_reg <= merge16(con2_reg, w_data_reg, w_strb_reg, `ASQ_CON2_WMASK);
				`ASQ_ADDR_TIMING:
					timing_reg <= merge16(timing_reg, w_data_reg, w_strb_reg,
						`ASQ_TIMING_WMASK);
				`ASQ_ADDR_BUFSIZE:
					bufsize_reg <= merge16(bufsize_reg, w_data_reg, w_strb_reg,
						`ASQ_BUFSIZE_WMASK);
				`ASQ_ADDR_CHSEL:
					chsel_reg <= merge16(chsel_reg, w_data_reg, w_strb_reg,
						`ASQ_CHSEL_WMASK);
				`ASQ_ADDR_MODE:
					if (w_strb_reg[0]) begin
						auto_run_reg        <= w_data_reg[0];
						twelve_bit_mode_reg <= w_data_reg[1];
					end
				`ASQ_ADDR_IRQ_MASK:
					if (w_strb_reg[0])
						irq_mask_reg <= w_data_reg[1:0];
				default: ;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read path, one cycle after the address is taken
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `ASQ_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `ASQ_RESP_OKAY;
			case (s_axi_araddr)
			`ASQ_ADDR_CON2:    s_axi_rdata <= {16'h0000, con2_reg};
			`ASQ_ADDR_TIMING:  s_axi_rdata <= {16'h0000, timing_reg};
			`ASQ_ADDR_BUFSIZE: s_axi_rdata <= {16'h0000, bufsize_reg};
			// Channel selects, positive and negative, read zero in 12-bit mode
			`ASQ_ADDR_CHSEL:   s_axi_rdata <= {16'h0000, twelve_bit_mode_reg ?
				16'h0000 : chsel_reg};
			`ASQ_ADDR_MODE:    s_axi_rdata <= {27'h0000000, state_reg,
				twelve_bit_mode_reg, auto_run_reg};
			`ASQ_ADDR_IRQ_STATUS: s_axi_rdata <= {30'h00000000, irq_status_reg};
			`ASQ_ADDR_IRQ_MASK:   s_axi_rdata <= {30'h00000000, irq_mask_reg};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `ASQ_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Sample then convert, timed in conversion-clock periods
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg    <= ST_IDLE;
			tad_cnt_reg  <= 5'h00;
			rate_cnt_reg <= 4'h0;
			sampling     <= 1'b0;
			converting   <= 1'b0;
			conv_done    <= 1'b0;
		end else begin
			conv_done <= conv_end;
			case (state_reg)
			ST_IDLE: begin
				tad_cnt_reg <= 5'h00;
				if (trigger || auto_run_reg) begin
					state_reg <= ST_SAMPLE;
					sampling  <= 1'b1;
				end
			end
			ST_SAMPLE: begin
				if (auto_sample_time_field == 5'h00 ||
					(tad_tick && tad_cnt_reg == auto_sample_time_field - 5'h01)) begin
					state_reg   <= ST_CONV;
					sampling    <= 1'b0;
					converting  <= 1'b1;
					tad_cnt_reg <= 5'h00;
				end else if (tad_tick) begin
					tad_cnt_reg <= tad_cnt_reg + 5'h01;
				end
			end
			ST_CONV: begin
				if (conv_end) begin
					state_reg    <= ST_IDLE;
					converting   <= 1'b0;
					rate_cnt_reg <= step_now ? 4'h0 : rate_cnt_reg + 4'h1;
				end else if (tad_tick) begin
					tad_cnt_reg <= tad_cnt_reg + 5'h01;
				end
			end
			default: begin
				state_reg  <= ST_IDLE;
				sampling   <= 1'b0;
				converting <= 1'b0;
			end
			endcase
		end
	end

	// DMA pointer walks within the per-input area, base from the input index
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ptr_reg  <= {AW{1'b0}};
			dma_addr <= {AW{1'b0}};
			dma_step <= 1'b0;
		end else begin
			dma_step <= step_now;
			if (step_now)
				ptr_reg <= (ptr_reg + 1'b1) & ((({{(AW-1){1'b0}}, 1'b1}) <<
					buffer_size_per_input) - 1'b1);
			dma_addr <= (({{(AW-5){1'b0}}, input_index}) << buffer_size_per_input) |
				ptr_reg;
		end
	end

	// Sticky status, set wins over the read clear
	always @(posedge sys_clk) begin
		if (sys_rst)
			irq_status_reg <= 2'b00;
		else
			irq_status_reg <= (rd_status ? 2'b00 : irq_status_reg) |
				{conv_end, step_now};
	end
	assign irq = |(irq_status_reg & irq_mask_reg);

	// Input routing
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			pos_sel_a <= 15'h0000;
			pos_sel_b <= 15'h0000;
			neg_sel_a <= 15'h0000;
			neg_sel_b <= 15'h0000;
			neg_ref_a <= 3'h0;
			neg_ref_b <= 3'h0;
		end else begin
			pos_sel_a <= trio(positive_select_slot_a ? 5'd3 : 5'd0);
			pos_sel_b <= trio(positive_select_slot_b ? 5'd3 : 5'd0);
			neg_sel_a <= trio(negative_select_slot_a[0] ? 5'd9 : 5'd6);
			neg_sel_b <= trio(negative_select_slot_b[0] ? 5'd9 : 5'd6);
			neg_ref_a <= {3{twelve_bit_mode_reg | ~negative_select_slot_a[1]}};
			neg_ref_b <= {3{twelve_bit_mode_reg | ~negative_select_slot_b[1]}};
		end
	end
endmodule

// ### design/asq_consts.vh
`ifndef ASQ_CONSTS_VH
`define ASQ_CONSTS_VH

// Register byte addresses
`define ASQ_ADDR_CON2        5'h00
`define ASQ_ADDR_TIMING      5'h04
`define ASQ_ADDR_BUFSIZE     5'h08
`define ASQ_ADDR_CHSEL       5'h0c
`define ASQ_ADDR_MODE        5'h10
`define ASQ_ADDR_IRQ_STATUS  5'h14
`define ASQ_ADDR_IRQ_MASK    5'h18

// Field positions
`define ASQ_RATE_LSB         2
`define ASQ_AUTO_SAMPLE_TIME_FIELD_LSB         8
`define ASQ_CLKSEL_LSB       0
`define ASQ_BUFLEN_LSB       0
`define ASQ_POSA_BIT         0
`define ASQ_NEGA_LSB         1
`define ASQ_POSB_BIT         8
`define ASQ_NEGB_LSB         9

// Writable masks and reset values
`define ASQ_CON2_WMASK       16'h003c
`define ASQ_TIMING_WMASK     16'h1fff
`define ASQ_BUFSIZE_WMASK    16'h0007
`define ASQ_CHSEL_WMASK      16'h0707
`define ASQ_CON2_RST         16'h0000
`define ASQ_TIMING_RST       16'h0000
`define ASQ_BUFSIZE_RST      16'h0000
`define ASQ_CHSEL_RST        16'h0000

// Clock select limit and conversion timing
`define ASQ_CLKSEL_MAX       8'h3f
`define ASQ_CONV_TAD         12

// Interrupt status bits
`define ASQ_IRQ_STEP         0
`define ASQ_IRQ_CONV         1

// AXI responses
`define ASQ_RESP_OKAY        2'b00
`define ASQ_RESP_SLVERR      2'b10

`endif

// ### design/asq_clk_div.v
`timescale 1ns/100ps
`include "asq_consts.vh"

// Conversion clock tick: one pulse every (sel + 1) instruction cycles
module asq_clk_div #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         sys_clk,
	input  wire         sys_rst,
	// Control
	input  wire [W-1:0] sel,
	input  wire         run,
	// Tick out
	output reg          tick
);
	reg [W-1:0] cnt_reg;

	// Tick straight from the count so the first period after start is not one cycle long
	always @* begin
		tick = !sys_rst && run && (cnt_reg >= sel);
	end

	always @(posedge sys_clk) begin
		if (sys_rst || !run || tick) begin
			cnt_reg <= {W{1'b0}};
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

// ### test/asq_seq_ctrl_sva.sv
`timescale 1ns/100ps
module asq_seq_ctrl_sva (
	// Clock and reset
	input wire        sys_clk,
	input wire        sys_rst,
	// Bus handshakes
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	// Sequencer
	input wire        sampling,
	input wire        converting,
	input wire        conv_done,
	input wire        dma_step,
	// Routing
	input wire [14:0] pos_sel_a,
	input wire [14:0] neg_sel_a,
	input wire [2:0]  neg_ref_a
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	step_on_done_a: assert property (dma_step |-> conv_done)
		else $error("step without conversion end");
	conv_length_a: assert property ($rose(converting) |=> converting [*8])
		else $error("conversion too short");
	done_after_a: assert property ($fell(converting) |-> ##[0:1] conv_done)
		else $error("no done after conversion");
	pos_route_a: assert property (!$past(sys_rst) |-> pos_sel_a inside {{5'd2, 5'd1, 5'd0}, {5'd5, 5'd4, 5'd3}})
		else $error("bad positive routing");
	neg_route_a: assert property (!$past(sys_rst) && neg_ref_a == 3'b000 |-> neg_sel_a inside {{5'd8, 5'd7, 5'd6}, {5'd11, 5'd10, 5'd9}})
		else $error("bad negative routing");
	neg_ref_code_a: assert property (neg_ref_a inside {3'b000, 3'b111})
		else $error("mixed reference select");
	phase_excl_a: assert property (!(sampling && converting))
		else $error("sampling while converting");
	cover property (dma_step);
	cover property (conv_done && !dma_step);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind asq_seq_ctrl asq_seq_ctrl_sva chk_u (.*);

// ### test/asq_dma_model.sv
`timescale 1ns/100ps
// Far-side DMA channel: fixed input index, keeps the last step address
module asq_dma_model #(
	parameter IDX = 5'd3
) (
	// Clock and reset
	input  wire         sys_clk,
	input  wire         sys_rst,
	// From the block
	input  wire         dma_step,
	input  wire [10:0]  dma_addr,
	// To block and bench
	output logic [4:0]  input_index,
	output logic [10:0] step_addr
);
	assign input_index = IDX;
	always @(posedge sys_clk) begin
		if (sys_rst)
			step_addr <= 11'h7ff;
		else if (dma_step)
			step_addr <= dma_addr;
	end
endmodule

// ### test/asq_seq_ctrl_test.sv
`timescale 1ns/100ps
`include "asq_consts.vh"
module asq_seq_ctrl_test;
	typedef struct {logic [4:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} asq_row_t;
	logic        sys_clk, sys_rst, trigger;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, d;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [1:0]  r;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         sampling, converting, conv_done, dma_step, irq;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [10:0]  dma_addr, step_addr;
	wire [4:0]   input_index;
	wire [14:0]  pos_sel_a, pos_sel_b, neg_sel_a, neg_sel_b;
	wire [2:0]   neg_ref_a, neg_ref_b;
	int          fails, total_checks, ns, nc, st;
	asq_row_t    rows [5] = '{
		'{5'h00, 32'hffffffff, 32'h003c, 2'b00},
		'{5'h04, 32'hffffffff, 32'h1fff, 2'b00},
		'{5'h08, 32'hffffffff, 32'h0007, 2'b00},
		'{5'h0c, 32'h00000407, 32'h0407, 2'b00},
		'{5'h1c, 32'hffffffff, 32'h0000, 2'b10}
	};

	asq_seq_ctrl dut_u (.*);
	asq_dma_model dma_u (.*);

	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s: expected %h, seen %h", n, e, g);
		end
	endtask

	task wr(input logic [4:0] a, input logic [31:0] w, output logic [1:0] resp);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	task rd(input logic [4:0] a, output logic [31:0] data, output logic [1:0] resp);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// One triggered conversion, phase cycles summed for timing checks
	task automatic conv();
		int n;
		n = 0;
		trigger <= 1;
		@(posedge sys_clk);
		trigger <= 0;
		do begin
			@(posedge sys_clk);
			n++;
			ns += sampling;
			nc += converting;
		end while (!conv_done && n < 400);
		st += dma_step;
		if (n >= 400) fails++;
	endtask

	task give_verdict;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		fails++;
		give_verdict;
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, trigger} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
		sys_rst = 1;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 0;
		for (int i = 0; i < 4; i++) begin
			rd(5'(i * 4), d, r);
			chk("reset value", 0, d);
		end
		chk("pos_sel_a", {5'd2, 5'd1, 5'd0}, pos_sel_a);
		chk("neg_ref_a", 3'b111, neg_ref_a);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, r);
			chk("write resp", rows[i].r, r);
			rd(rows[i].a, d, r);
			chk("read resp", rows[i].r, r);
			chk("read data", rows[i].e, d);
		end
		chk("pos_sel_a", {5'd5, 5'd4, 5'd3}, pos_sel_a);
		chk("pos_sel_b", {5'd2, 5'd1, 5'd0}, pos_sel_b);
		chk("neg_sel_a", {5'd11, 5'd10, 5'd9}, neg_sel_a);
		chk("neg_sel_b", {5'd8, 5'd7, 5'd6}, neg_sel_b);
		chk("neg_ref", 0, {neg_ref_a, neg_ref_b});
		wr(`ASQ_ADDR_MODE, 2, r);
		rd(`ASQ_ADDR_CHSEL, d, r);
		chk("chsel 12-bit", 0, d);
		chk("neg_ref_b", 3'b111, neg_ref_b);
		wr(`ASQ_ADDR_MODE, 0, r);
		// Two-cycle conversion clock, two-period sample, step every third
		wr(`ASQ_ADDR_TIMING, 32'h0201, r);
		wr(`ASQ_ADDR_BUFSIZE, 1, r);
		wr(`ASQ_ADDR_CON2, 32'h08, r);
		wr(`ASQ_ADDR_IRQ_MASK, 1, r);
		for (int i = 0; i < 3; i++) begin
			conv();
			chk("dma steps", i == 2, st);
		end
		chk("convert cycles", 72, nc);
		chk("sample cycles", 12, ns);
		repeat (2) @(posedge sys_clk);
		chk("dma area", 3, step_addr >> 1);
		chk("irq", 1, irq);
		rd(`ASQ_ADDR_IRQ_STATUS, d, r);
		chk("irq status", 3, d);
		@(posedge sys_clk);
		chk("irq", 0, irq);
		wr(`ASQ_ADDR_IRQ_MASK, 0, r);
		repeat (3) conv();
		chk("dma steps", 2, st);
		chk("irq", 0, irq);
		rd(`ASQ_ADDR_IRQ_STATUS, d, r);
		chk("irq status", 3, d);
		sys_rst <= 1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 0;
		rd(`ASQ_ADDR_TIMING, d, r);
		chk("reset value", 0, d);
		give_verdict;
	end
endmodule
